// ### hw/wolrf_byte_order.sv
// Receive byte reordering ahead of the wake filter
module wolrf_byte_order
(
   input  wire logic [1:0] ord,
   input  wire logic [7:0] din,
   output logic      [7:0] dout
);
   import wolrf_pkg::*;

   logic [7:0] rev_all;
   logic [7:0] rev_nib;

   for (genvar i = 0; i < 8; i++)
   begin : g_rev
      assign rev_all[i] = din[7 - i];
      assign rev_nib[i] = din[(i & 4) + 3 - (i & 3)];
   end

   // [RL1] Order select
   always_comb
   begin
      case (ord)
         WOLRF_ORD_NORMAL : dout = din;
         WOLRF_ORD_BITREV : dout = rev_all;
         WOLRF_ORD_SWAPN  : dout = {din[3:0], din[7:4]};
         default          : dout = rev_nib;
      endcase
   end

endmodule

// ### hw/wolrf_pkg.sv
// Constants shared by the wake-on-LAN receive filter files
package wolrf_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] WOLRF_CFG_ADDR  = 16'h04a0;
   localparam logic [15:0] WOLRF_STAT_ADDR = 16'h04a1;
   localparam logic [15:0] WOLRF_MAC2_ADDR = 16'h04a2;
   localparam logic [15:0] WOLRF_MAC1_ADDR = 16'h04a3;
   localparam logic [15:0] WOLRF_MAC0_ADDR = 16'h04a4;
   localparam logic [15:0] WOLRF_PW0_ADDR  = 16'h04a5;
   localparam logic [15:0] WOLRF_PW1_ADDR  = 16'h04a6;
   localparam logic [15:0] WOLRF_PW2_ADDR  = 16'h04a7;
   localparam logic [15:0] WOLRF_PAT0_ADDR = 16'h04a8;
   localparam logic [15:0] WOLRF_PAT1_ADDR = 16'h04a9;
   localparam logic [15:0] WOLRF_PAT2_ADDR = 16'h04aa;

   // ****************************************
   // Configuration fields
   // ****************************************
   localparam int WOLRF_CFG_ORD_HI   = 15;
   localparam int WOLRF_CFG_ORD_LO   = 14;
   localparam int WOLRF_CFG_SFD_ALT  = 13;
   localparam int WOLRF_CFG_CRC_GATE = 12;
   localparam int WOLRF_CFG_LVL_CLR  = 11;
   localparam int WOLRF_CFG_WID_HI   = 10;
   localparam int WOLRF_CFG_WID_LO   = 9;
   localparam int WOLRF_CFG_LEVEL    = 8;
   localparam int WOLRF_CFG_WOL_EN   = 7;
   localparam int WOLRF_CFG_SECURE   = 5;
   localparam int WOLRF_CFG_PAT_EN   = 1;
   localparam int WOLRF_CFG_MAGIC_EN = 0;
   localparam logic [15:0] WOLRF_CFG_RST   = 16'h1000;
   localparam logic [15:0] WOLRF_CFG_WMASK = 16'hf7ff;

   // Status fields
   localparam int WOLRF_ST_SRC   = 12;
   localparam int WOLRF_ST_HACK  = 5;
   localparam int WOLRF_ST_PAT   = 1;
   localparam int WOLRF_ST_MAGIC = 0;

   // ****************************************
   // Frame constants
   // ****************************************
   localparam logic [1:0] WOLRF_ORD_NORMAL = 2'h0;
   localparam logic [1:0] WOLRF_ORD_BITREV = 2'h1;
   localparam logic [1:0] WOLRF_ORD_SWAPN  = 2'h2;
   localparam logic [1:0] WOLRF_ORD_NIBREV = 2'h3;
   localparam logic [7:0] WOLRF_SFD_NORMAL = 8'hd5;
   localparam logic [7:0] WOLRF_SFD_ALT    = 8'h5d;
   localparam logic [7:0] WOLRF_SYNC_BYTE  = 8'hff;
   localparam logic [2:0] WOLRF_SYNC_LEN   = 3'h6;
   localparam logic [2:0] WOLRF_LAST_BYTE  = 3'h5;
   localparam logic [2:0] WOLRF_PAT_LEN    = 3'h6;
   localparam logic [3:0] WOLRF_COPY_LAST  = 4'hf;

   // ****************************************
   // Wake pulse timing
   // ****************************************
   localparam int WOLRF_REF_PERIOD_PS = 8000;
   localparam int WOLRF_CLK_PERIOD_PS = 10000;
   localparam logic [6:0] WOLRF_PULSE8_CYC = 7'((8 * WOLRF_REF_PERIOD_PS
      + WOLRF_CLK_PERIOD_PS - 1) / WOLRF_CLK_PERIOD_PS);
   localparam logic [6:0] WOLRF_PULSE16_CYC = 7'((16 * WOLRF_REF_PERIOD_PS
      + WOLRF_CLK_PERIOD_PS - 1) / WOLRF_CLK_PERIOD_PS);
   localparam logic [6:0] WOLRF_PULSE32_CYC = 7'((32 * WOLRF_REF_PERIOD_PS
      + WOLRF_CLK_PERIOD_PS - 1) / WOLRF_CLK_PERIOD_PS);
   localparam logic [6:0] WOLRF_PULSE64_CYC = 7'((64 * WOLRF_REF_PERIOD_PS
      + WOLRF_CLK_PERIOD_PS - 1) / WOLRF_CLK_PERIOD_PS);

   typedef enum logic [1:0]
   {
      WOLRF_FR_IDLE = 2'h0,
      WOLRF_FR_HUNT = 2'h1,
      WOLRF_FR_BODY = 2'h3
   } wolrf_frame_t;

endpackage

// ### hw/wolrf_rx_filter.sv
// Wake-on-LAN receive filter with its configuration registers
// Operation
// [RL1] Received byte is reordered by a two-bit field before filtering.
// [RL2] Delimiter searched is 0x5D when select bit set, else 0xD5.
// [RL3] CRC gate set: bad-CRC frame yields no status, interrupt or wake.
// [RL4] Writing level-clear drops held wake level; bit reads back zero.
// [RL5] Pulse mode width 8, 16, 32 or 64 reference clock cycles.
// [RL6] Indication select one gives held level, zero gives timed pulse.
// [RL7] Frame detection runs only while wake enable bit is one.
// [RL8] Password enable requires six-byte password inside magic packet.
// [RL9] Pattern enable raises interrupt on frame matching the pattern.
// [RL10] Magic enable raises interrupt on a valid magic packet.
// [RL11] Enabling wake switches interrupt source select to wake event.
// [RL12] Valid magic packet sets latched, read-cleared status flag.
// [RL13] Wrong password in magic packet sets latched, read-cleared flag.
// [RL14] Magic packet: six FF bytes then sixteen address copies, anywhere.
//
// The plain strobed port was left to the implementer.
module wolrf_rx_filter
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        rx_dv,
   input  wire logic        rx_byte_vld,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_end,
   input  wire logic        rx_crc_bad,
   output logic             wake_out,
   output logic             wake_irq,
   output logic             irq_src_wol
);
   import wolrf_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed
   {
      logic [15:0]  cfg;
      logic         src_wol;
      logic         hack;
      logic         pat_st;
      logic         magic_st;
      logic [47:0]  mac;
      logic [47:0]  pw;
      logic [47:0]  pat;
      wolrf_frame_t fr;
      logic [2:0]   sync_cnt;
      logic         addr_ph;
      logic [2:0]   byte_idx;
      logic [3:0]   copy_cnt;
      logic         magic_seen;
      logic         pw_ph;
      logic [2:0]   pw_idx;
      logic         pw_ok;
      logic [2:0]   pat_idx;
      logic         pat_ok;
      logic [15:0]  rdata;
      logic         irq;
      logic         trig;
      logic         clr;
   } wolrf_state_t;

   wolrf_state_t st_ff;
   wolrf_state_t nxt_st;

   logic [7:0] ord_byte;
   logic [7:0] sfd_val;
   logic       wol_en;
   logic       byte_ok;
   logic       end_ok;
   logic       pw_good;
   logic       magic_ev;
   logic       hack_ev;
   logic       pat_ev;

   // Byte k of a six-byte field, lowest byte first
   function automatic logic [7:0] pick(input logic [47:0] v,
                                       input logic [2:0]  k);
      pick = v[8 * k +: 8];
   endfunction

   // Address bytes sit highest first in the field
   function automatic logic [7:0] mac_byte(input logic [47:0] v,
                                           input logic [2:0]  k);
      mac_byte = pick(v, WOLRF_LAST_BYTE - k);
   endfunction

   function automatic logic [15:0] stat_word(input wolrf_state_t s);
      stat_word = '0;
      stat_word[WOLRF_ST_SRC] = s.src_wol;
      stat_word[WOLRF_ST_HACK] = s.hack;
      stat_word[WOLRF_ST_PAT] = s.pat_st;
      stat_word[WOLRF_ST_MAGIC] = s.magic_st;
   endfunction

   // ****************************************
   // Data path
   // ****************************************
   wolrf_byte_order u_order
   (
      .ord  (st_ff.cfg[WOLRF_CFG_ORD_HI:WOLRF_CFG_ORD_LO]),
      .din  (rx_byte),
      .dout (ord_byte)
   );

   // [RL2] Delimiter select
   assign sfd_val = st_ff.cfg[WOLRF_CFG_SFD_ALT] ? WOLRF_SFD_ALT
                                                 : WOLRF_SFD_NORMAL;
   assign wol_en  = st_ff.cfg[WOLRF_CFG_WOL_EN];
   assign byte_ok = rx_dv && rx_byte_vld;

   // [RL3] With the CRC gate set, bad CRC suppresses every indication
   assign end_ok = (st_ff.fr == WOLRF_FR_BODY) && rx_end && wol_en
                   && !(st_ff.cfg[WOLRF_CFG_CRC_GATE] && rx_crc_bad);
   // Short frame ending inside the password counts as a mismatch
   assign pw_good = st_ff.pw_ok && !st_ff.pw_ph;
   // [RL8] Password gates the magic packet
   assign magic_ev = end_ok && st_ff.magic_seen
                     && (!st_ff.cfg[WOLRF_CFG_SECURE] || pw_good);
   assign hack_ev  = end_ok && st_ff.magic_seen
                     && st_ff.cfg[WOLRF_CFG_SECURE] && !pw_good;
   assign pat_ev   = end_ok && st_ff.pat_ok
                     && (st_ff.pat_idx == WOLRF_PAT_LEN);

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      nxt_st.irq = 1'b0;
      nxt_st.trig = 1'b0;
      nxt_st.clr = 1'b0;

      // Register writes
      if (reg_wr)
      begin
         case (reg_addr)
            WOLRF_CFG_ADDR :
            begin
               nxt_st.cfg = reg_wdata & WOLRF_CFG_WMASK;
               // [RL4] Self-clearing level clear
               nxt_st.clr = reg_wdata[WOLRF_CFG_LVL_CLR];
               // [RL11] Source set when wake enable goes from zero to one; clearing enable leaves it
               if (reg_wdata[WOLRF_CFG_WOL_EN] && !wol_en)
                  nxt_st.src_wol = 1'b1;
            end
            WOLRF_STAT_ADDR : nxt_st.src_wol = reg_wdata[WOLRF_ST_SRC];
            WOLRF_MAC2_ADDR : nxt_st.mac[15:0] = reg_wdata;
            WOLRF_MAC1_ADDR : nxt_st.mac[31:16] = reg_wdata;
            WOLRF_MAC0_ADDR : nxt_st.mac[47:32] = reg_wdata;
            WOLRF_PW0_ADDR  : nxt_st.pw[15:0] = reg_wdata;
            WOLRF_PW1_ADDR  : nxt_st.pw[31:16] = reg_wdata;
            WOLRF_PW2_ADDR  : nxt_st.pw[47:32] = reg_wdata;
            WOLRF_PAT0_ADDR : nxt_st.pat[15:0] = reg_wdata;
            WOLRF_PAT1_ADDR : nxt_st.pat[31:16] = reg_wdata;
            WOLRF_PAT2_ADDR : nxt_st.pat[47:32] = reg_wdata;
            default         : nxt_st.clr = 1'b0;
         endcase
      end

      // Register reads; unmapped reads return zero
      if (reg_rd)
      begin
         case (reg_addr)
            WOLRF_CFG_ADDR :
               nxt_st.rdata = st_ff.cfg;
            WOLRF_STAT_ADDR :
            begin
               nxt_st.rdata = stat_word(st_ff);
               // [RL12] Flags clear on read
               nxt_st.hack = 1'b0;
               nxt_st.pat_st = 1'b0;
               nxt_st.magic_st = 1'b0;
            end
            WOLRF_MAC2_ADDR : nxt_st.rdata = st_ff.mac[15:0];
            WOLRF_MAC1_ADDR : nxt_st.rdata = st_ff.mac[31:16];
            WOLRF_MAC0_ADDR : nxt_st.rdata = st_ff.mac[47:32];
            WOLRF_PW0_ADDR  : nxt_st.rdata = st_ff.pw[15:0];
            WOLRF_PW1_ADDR  : nxt_st.rdata = st_ff.pw[31:16];
            WOLRF_PW2_ADDR  : nxt_st.rdata = st_ff.pw[47:32];
            WOLRF_PAT0_ADDR : nxt_st.rdata = st_ff.pat[15:0];
            WOLRF_PAT1_ADDR : nxt_st.rdata = st_ff.pat[31:16];
            WOLRF_PAT2_ADDR : nxt_st.rdata = st_ff.pat[47:32];
            default         : nxt_st.rdata = '0;
         endcase
      end

      // Frame tracking
      case (st_ff.fr)
         WOLRF_FR_IDLE :
         begin
            // [RL7] Detection only while enabled
            if (wol_en && rx_dv)
               nxt_st.fr = WOLRF_FR_HUNT;
         end
         WOLRF_FR_HUNT :
         begin
            if (!rx_dv || !wol_en)
               nxt_st.fr = WOLRF_FR_IDLE;
            // [RL2] Delimiter found
            else if (byte_ok && ord_byte == sfd_val)
            begin
               nxt_st.fr = WOLRF_FR_BODY;
               nxt_st.sync_cnt = '0;
               nxt_st.addr_ph = 1'b0;
               nxt_st.byte_idx = '0;
               nxt_st.copy_cnt = '0;
               nxt_st.magic_seen = 1'b0;
               nxt_st.pw_ph = 1'b0;
               nxt_st.pw_idx = '0;
               nxt_st.pw_ok = 1'b0;
               nxt_st.pat_idx = '0;
               nxt_st.pat_ok = 1'b1;
            end
         end
         WOLRF_FR_BODY :
         begin
            // [RL7] Disable abandons the frame
            if (!wol_en || rx_end)
               nxt_st.fr = WOLRF_FR_IDLE;
            else if (byte_ok)
            begin
               // [RL14] Address copies after sync run
               if (st_ff.addr_ph)
               begin
                  if (ord_byte == mac_byte(st_ff.mac, st_ff.byte_idx))
                  begin
                     if (st_ff.byte_idx != WOLRF_LAST_BYTE)
                        nxt_st.byte_idx = st_ff.byte_idx + 3'h1;
                     else if (st_ff.copy_cnt != WOLRF_COPY_LAST)
                     begin
                        nxt_st.byte_idx = '0;
                        nxt_st.copy_cnt = st_ff.copy_cnt + 4'h1;
                     end
                     else
                     begin
                        nxt_st.addr_ph = 1'b0;
                        nxt_st.magic_seen = 1'b1;
                        nxt_st.pw_ph = 1'b1;
                        nxt_st.pw_idx = '0;
                        nxt_st.pw_ok = 1'b1;
                     end
                  end
                  else
                  begin
                     // Mismatch restarts the search at this byte
                     nxt_st.addr_ph = 1'b0;
                     nxt_st.sync_cnt = (ord_byte == WOLRF_SYNC_BYTE)
                                       ? 3'h1 : 3'h0;
                  end
               end
               // [RL14] Sync run of FF bytes
               else if (!st_ff.magic_seen)
               begin
                  if (ord_byte == WOLRF_SYNC_BYTE)
                  begin
                     if (st_ff.sync_cnt != WOLRF_SYNC_LEN)
                        nxt_st.sync_cnt = st_ff.sync_cnt + 3'h1;
                  end
                  else if (st_ff.sync_cnt == WOLRF_SYNC_LEN
                           && ord_byte == mac_byte(st_ff.mac, '0))
                  begin
                     nxt_st.addr_ph = 1'b1;
                     nxt_st.byte_idx = 3'h1;
                     nxt_st.copy_cnt = '0;
                  end
                  else
                     nxt_st.sync_cnt = '0;
               end
               // [RL8] Password follows the last copy
               if (st_ff.pw_ph)
               begin
                  if (ord_byte != pick(st_ff.pw, st_ff.pw_idx))
                     nxt_st.pw_ok = 1'b0;
                  if (st_ff.pw_idx == WOLRF_LAST_BYTE)
                     nxt_st.pw_ph = 1'b0;
                  else
                     nxt_st.pw_idx = st_ff.pw_idx + 3'h1;
               end
               // Pattern compared against the first payload bytes
               if (st_ff.pat_idx != WOLRF_PAT_LEN)
               begin
                  if (ord_byte != pick(st_ff.pat, st_ff.pat_idx))
                     nxt_st.pat_ok = 1'b0;
                  nxt_st.pat_idx = st_ff.pat_idx + 3'h1;
               end
            end
         end
         default : nxt_st.fr = WOLRF_FR_IDLE;
      endcase

      // Events; a set beats a read clear in the same cycle
      // [RL12] Magic status
      if (magic_ev)
         nxt_st.magic_st = 1'b1;
      // [RL13] Password mismatch flag
      if (hack_ev)
         nxt_st.hack = 1'b1;
      if (pat_ev)
         nxt_st.pat_st = 1'b1;
      // [RL10] Magic interrupt and wake
      // [RL9] Pattern interrupt and wake
      if ((magic_ev && st_ff.cfg[WOLRF_CFG_MAGIC_EN])
          || (pat_ev && st_ff.cfg[WOLRF_CFG_PAT_EN]))
      begin
         nxt_st.irq = 1'b1;
         nxt_st.trig = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st_ff <= '0;
         st_ff.cfg <= WOLRF_CFG_RST;
         st_ff.fr <= WOLRF_FR_IDLE;
      end
      else
         st_ff <= nxt_st;
   end

   // ****************************************
   // Indication and outputs
   // ****************************************
   // [RL5] Width and mode steer the indicator
   wolrf_wake_ind u_ind
   (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .trig      (st_ff.trig),
      .lvl_mode  (st_ff.cfg[WOLRF_CFG_LEVEL]),
      .width_sel (st_ff.cfg[WOLRF_CFG_WID_HI:WOLRF_CFG_WID_LO]),
      .lvl_clr   (st_ff.clr),
      .wake_out  (wake_out)
   );

   assign reg_rdata   = st_ff.rdata;
   assign wake_irq    = st_ff.irq;
   assign irq_src_wol = st_ff.src_wol;

   // ****************************************
   // Checks
   // ****************************************
   nibble_swap_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL1]
      st_ff.cfg[WOLRF_CFG_ORD_HI:WOLRF_CFG_ORD_LO] == WOLRF_ORD_SWAPN
      |-> ord_byte == {rx_byte[3:0], rx_byte[7:4]})
      else $error("nibble swap order wrong");

   sfd_hunt_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL2]
      st_ff.fr == WOLRF_FR_HUNT && wol_en && byte_ok
      && ord_byte == sfd_val |=> st_ff.fr == WOLRF_FR_BODY)
      else $error("delimiter not taken");

   crc_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL3]
      rx_end && rx_crc_bad && st_ff.cfg[WOLRF_CFG_CRC_GATE]
      |=> !wake_irq && !st_ff.trig)
      else $error("bad CRC frame gave an indication");

   level_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL4]
      reg_wr && reg_addr == WOLRF_CFG_ADDR
      && reg_wdata[WOLRF_CFG_LVL_CLR] && reg_wdata[WOLRF_CFG_LEVEL]
      && !st_ff.trig ##1 !st_ff.trig |=> !wake_out)
      else $error("level clear ignored");

   wol_off_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL7]
      !wol_en |=> st_ff.fr == WOLRF_FR_IDLE && !st_ff.trig)
      else $error("detection while disabled");

   pw_block_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL8]
      end_ok && st_ff.magic_seen && st_ff.cfg[WOLRF_CFG_SECURE] && !pw_good
      && !st_ff.magic_st |=> !st_ff.magic_st && st_ff.hack)
      else $error("magic accepted without password");

   pat_irq_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL9]
      pat_ev && st_ff.cfg[WOLRF_CFG_PAT_EN] |=> wake_irq ##2 wake_out)
      else $error("pattern interrupt missing");

   magic_irq_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL10]
      magic_ev && st_ff.cfg[WOLRF_CFG_MAGIC_EN] |=> wake_irq && st_ff.trig)
      else $error("magic interrupt missing");

   src_switch_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL11]
      reg_wr && reg_addr == WOLRF_CFG_ADDR && reg_wdata[WOLRF_CFG_WOL_EN]
      && !wol_en |=> irq_src_wol)
      else $error("interrupt source not switched");

   magic_clr_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL12]
      reg_rd && reg_addr == WOLRF_STAT_ADDR && !magic_ev
      |=> !st_ff.magic_st)
      else $error("magic status not cleared on read");

   hack_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL13]
      hack_ev |=> st_ff.hack ##1 (st_ff.hack || $past(reg_rd)))
      else $error("password mismatch flag lost");

   magic_copies_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL14]
      $rose(st_ff.magic_seen) |-> $past(st_ff.copy_cnt) == WOLRF_COPY_LAST
      && $past(st_ff.byte_idx) == WOLRF_LAST_BYTE)
      else $error("magic seen before sixteen copies");

endmodule

// ### hw/wolrf_wake_ind.sv
// Wake indication output: timed pulse or held level
module wolrf_wake_ind
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic       trig,
   input  wire logic       lvl_mode,
   input  wire logic [1:0] width_sel,
   input  wire logic       lvl_clr,
   output logic            wake_out
);
   import wolrf_pkg::*;

   typedef struct packed
   {
      logic       act;
      logic [6:0] cnt;
   } wolrf_ind_t;

   wolrf_ind_t st_ff;
   wolrf_ind_t nxt_st;

   function automatic logic [6:0] pulse_cyc(input logic [1:0] sel);
      case (sel)
         2'h0    : pulse_cyc = WOLRF_PULSE8_CYC;
         2'h1    : pulse_cyc = WOLRF_PULSE16_CYC;
         2'h2    : pulse_cyc = WOLRF_PULSE32_CYC;
         default : pulse_cyc = WOLRF_PULSE64_CYC;
      endcase
   endfunction

   always_comb
   begin
      nxt_st = st_ff;
      if (lvl_mode)
      begin
         // [RL4] Clear held level
         if (lvl_clr)
            nxt_st.act = 1'b0;
      end
      else if (st_ff.act)
      begin
         if (st_ff.cnt == '0)
            nxt_st.act = 1'b0;
         else
            nxt_st.cnt = st_ff.cnt - 7'h01;
      end
      // [RL6] New event wins over clear
      if (trig)
      begin
         nxt_st.act = 1'b1;
         nxt_st.cnt = pulse_cyc(width_sel) - 7'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign wake_out = st_ff.act;

   // [RL5] Pulse width load
   pulse_load_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL5]
      trig && !lvl_mode |=> wake_out && st_ff.cnt == pulse_cyc(
      $past(width_sel)) - 7'h01)
      else $error("wake pulse not loaded with its width");

   // [RL5] Pulse ends on count
   pulse_end_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL5]
      wake_out && !lvl_mode && st_ff.cnt == '0 && !trig |=> !wake_out)
      else $error("wake pulse outlived its width");

   // [RL6] Level held
   level_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // [RL6]
      wake_out && lvl_mode && !lvl_clr ##1 lvl_mode && !lvl_clr
      |-> wake_out)
      else $error("wake level dropped without clear");

endmodule

// ### testbench/wolrf_rx_filter_tb.sv
// Self-checking bench of the wake-on-LAN receive filter
module wolrf_rx_filter_tb;
   import wolrf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
   logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata, hi_cnt, irq_cnt;
   logic rx_dv, rx_byte_vld, rx_end, rx_crc_bad, wake_out, wake_irq, src;
   logic [7:0] rx_byte, pb;
   logic [47:0] mac;
   logic [15:0] exp_q[$];
   int seed = 43, n_mismatch = 0, comparisons = 0;
   // Negative cases, the last one waking with the CRC gate off: config, wrong delimiter, bad crc, status, wake count
   logic [15:0] ncfg[6] = '{16'h1081, 16'h1081, 16'h1001, 16'h10a1,
                           16'h1080, 16'h0081};
   logic [5:0] nsfd = 6'b000010, nbad = 6'b100001;
   logic [15:0] nst[6] = '{16'h1000, 16'h1000, 16'h1000, 16'h1020,
                          16'h1001, 16'h1001};
   logic [15:0] wid[4] = '{16'h0007, 16'h000d, 16'h001a, 16'h0034};
   wolrf_rx_filter i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .rx_dv(rx_dv), .rx_byte_vld(rx_byte_vld),
      .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_bad(rx_crc_bad),
      .wake_out(wake_out), .wake_irq(wake_irq), .irq_src_wol(src));
   wolrf_station i_sta (.clk(clk), .rx_dv(rx_dv), .rx_byte_vld(rx_byte_vld),
      .rx_byte(rx_byte), .rx_end(rx_end), .rx_crc_bad(rx_crc_bad));
   initial forever #5 clk = ~clk;
   // ****************************************
   // Tasks
   // ****************************************
   task check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      if (n_mismatch == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge clk) reg_wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      @(posedge clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk) reg_rd <= 1'b0;
   endtask
   // Reordering is its own inverse, so the wire byte is ordf of the wanted
   function automatic logic [7:0] ordf(logic [1:0] o, logic [7:0] b);
      case (o)
         WOLRF_ORD_BITREV: return {<<{b}};
         WOLRF_ORD_SWAPN:  return {b[3:0], b[7:4]};
         WOLRF_ORD_NIBREV: return {{<<{b[7:4]}}, {<<{b[3:0]}}};
         default:          return b;
      endcase
   endfunction
   task frame(input logic [1:0] o, input logic alt, input logic bad);
      repeat (2) i_sta.q.push_back(ordf(o, 8'h55));
      i_sta.q.push_back(ordf(o, alt ? WOLRF_SFD_ALT : WOLRF_SFD_NORMAL));
      i_sta.q.push_back(ordf(o, pb));
      repeat (6) i_sta.q.push_back(ordf(o, WOLRF_SYNC_BYTE));
      repeat (16) for (int i = 0; i < 6; i++)
         i_sta.q.push_back(ordf(o, mac[47-8*i -: 8]));
      #1 hi_cnt = '0;
      irq_cnt = '0;
      i_sta.send(bad);
      pb = 8'($random(seed)) & 8'h7f;
      repeat (70) @(posedge clk);
   endtask
   // ****************************************
   // Watchers
   // ****************************************
   always @(posedge clk)
   begin
      rd_q <= reg_rd;
      hi_cnt <= hi_cnt + 16'(wake_out);
      irq_cnt <= irq_cnt + 16'(wake_irq);
      if (rd_q)
         check(reg_rdata, exp_q.pop_front());
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      mac = 48'({$random(seed), $random(seed)});
      mac[40] = 1'b0;
      pb = 8'($random(seed)) & 8'h7f;
      rd(WOLRF_CFG_ADDR, WOLRF_CFG_RST);
      wr(WOLRF_MAC0_ADDR, mac[47:32]);
      wr(WOLRF_MAC1_ADDR, mac[31:16]);
      wr(WOLRF_MAC2_ADDR, mac[15:0]);
      check(16'(src), 16'h0000);
      wr(WOLRF_CFG_ADDR, 16'h1081);
      rd(WOLRF_STAT_ADDR, 16'h1000);
      for (int k = 0; k < 4; k++)
      begin
         wr(WOLRF_CFG_ADDR, 16'h1081 | 16'(k) << 9 | 16'(k) << 14
            | 16'(k & 1) << 13);
         frame(2'(k), k[0], 1'b0);
         check(hi_cnt, wid[k]);
         check(irq_cnt, 16'h0001);
         rd(WOLRF_STAT_ADDR, 16'h1001);
         rd(WOLRF_STAT_ADDR, 16'h1000);
      end
      for (int n = 0; n < 6; n++)
      begin
         wr(WOLRF_CFG_ADDR, ncfg[n]);
         frame(WOLRF_ORD_NORMAL, nsfd[n], nbad[n]);
         check(irq_cnt, 16'(n / 5));
         check(hi_cnt, 16'(n / 5 * 7));
         rd(WOLRF_STAT_ADDR, nst[n]);
      end
      wr(WOLRF_PAT0_ADDR, {8'hff, pb});
      wr(WOLRF_PAT1_ADDR, 16'hffff);
      wr(WOLRF_PAT2_ADDR, 16'hffff);
      wr(WOLRF_CFG_ADDR, 16'h1082);
      frame(WOLRF_ORD_NORMAL, 1'b0, 1'b0);
      check(irq_cnt, 16'h0001);
      check(hi_cnt, 16'h0007);
      check(16'(src), 16'h0001);
      rd(WOLRF_STAT_ADDR, 16'h1003);
      wr(WOLRF_CFG_ADDR, 16'h1181);
      frame(WOLRF_ORD_NORMAL, 1'b0, 1'b0);
      check(16'(wake_out), 16'h0001);
      wr(WOLRF_CFG_ADDR, 16'h1981);
      repeat (3) @(posedge clk);
      check(16'(wake_out), 16'h0000);
      rd(WOLRF_CFG_ADDR, 16'h1181);
      repeat (3) @(posedge clk);
      finish_test;
   end
endmodule

// ### testbench/wolrf_station.sv
// Remote station model that feeds received frames into the filter
module wolrf_station
(
   input  wire logic  clk,
   output logic       rx_dv,
   output logic       rx_byte_vld,
   output logic [7:0] rx_byte,
   output logic       rx_end,
   output logic       rx_crc_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] q[$];
   initial {rx_dv, rx_byte_vld, rx_byte, rx_end, rx_crc_bad} = '0;
   // ****************************************
   // Frame sender
   // ****************************************
   // Released lines show the inverse, so a stale value never matches
   task send(input logic bad);
      @(posedge clk) rx_dv <= 1'b1;
      foreach (q[i])
      begin
         @(posedge clk) rx_byte_vld <= 1'b1;
         rx_byte <= q[i];
      end
      @(posedge clk) {rx_dv, rx_byte_vld, rx_end} <= 3'b001;
      rx_byte <= ~rx_byte;
      rx_crc_bad <= bad;
      @(posedge clk) rx_end <= 1'b0;
      rx_crc_bad <= ~bad;
      q.delete();
   endtask
endmodule
